// [common/stp_pkg.sv]
// Purpose: Constants and types for the serial link test pattern block
// Assumes: Two links of eight lanes, one octet per lane per clock
package stp_pkg;
    localparam int LINKS = 2;
    localparam int LANES_PER_LINK = 8;
    localparam int LANES = 16;
    localparam int OCTET_W = 8;
    localparam int PRBS_W = 31;
    localparam int FIFO_DEPTH = 32;
    localparam int SAMPLE_W = 128;

    // Test pattern selection codes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PRBS7 = 4'h1;
    localparam logic [3:0] MODE_PRBS9 = 4'h2;
    localparam logic [3:0] MODE_PRBS15 = 4'h3;
    localparam logic [3:0] MODE_PRBS23 = 4'h4;
    localparam logic [3:0] MODE_PRBS31 = 4'h5;
    localparam logic [3:0] MODE_CLOCK = 4'h6;
    localparam logic [3:0] MODE_RAMP = 4'h7;
    localparam logic [3:0] MODE_SHORT_TP = 4'h8;

    // Feedback taps as delays n-a, n-b
    localparam int TAP7_A = 6;
    localparam int TAP7_B = 7;
    localparam int TAP9_A = 5;
    localparam int TAP9_B = 9;
    localparam int TAP15_A = 14;
    localparam int TAP15_B = 15;
    localparam int TAP23_A = 18;
    localparam int TAP23_B = 23;
    localparam int TAP31_A = 28;
    localparam int TAP31_B = 31;
    localparam logic [30:0] PRBS_SEED_BASE = 31'h7fffff80;

    localparam logic [7:0] CLK_ONES = 8'hff;
    localparam logic [7:0] CLK_ZEROS = 8'h00;
    localparam logic [7:0] OCTET_MAX = 8'hff;
    localparam logic [7:0] RAMP_START = 8'h00;
    localparam logic [9:0] RAMP_K_LIMIT = 10'h100;
    localparam logic [3:0] NIB_TOP = 4'hf;
    localparam logic [3:0] TAIL_NIBBLE = 4'h0;
    localparam logic [3:0] LAST_NIBBLE = 4'hf;

    typedef enum logic [1:0] {RAMP_IDLE, RAMP_WAIT, RAMP_RUN} stp_ramp_t;
endpackage

// [design/stp_test_patterns.sv]
// Purpose: Lane test pattern generator with sample buffer
// Assumes: All control inputs come from logic on sys_clk
// Notes: One octet per lane per clock; lane l is link l/8, lane l%8
`timescale 1ns/1ps

module stp_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doPush;
    logic doPop;

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;
    assign outData = mem[rdPtr];

    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

module stp_test_patterns (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic [3:0] testPatternSelect,
    input wire logic linkEnable,
    // Decoded link format
    input wire logic [3:0] fmtLanesPerLink,
    input wire logic fmtNPrime12,
    input wire logic [4:0] fmtOctetsPerFrame,
    input wire logic [9:0] fmtFramesPerMulti,
    input wire logic fmt64b66b,
    // Link layer status
    input wire logic ilaDone,
    input wire logic serdesInitDone,
    input wire logic multiframeStart,
    input wire logic linkReady,
    // Formatted samples
    input wire logic [127:0] sampleData,
    input wire logic sampleValid,
    output logic sampleReady,
    // Lane output
    output logic [127:0] laneData,
    output logic laneValid,
    output logic rawSerial,
    output logic transportOff,
    output logic [15:0] lanePowerEn
);
    logic [3:0] activeMode;
    stp_pkg::stp_ramp_t rampState;
    logic [4:0] octetIdx;
    logic frameOdd;
    logic clkPhase;
    logic [7:0] rampCount;
    logic [7:0] rampOctet;
    logic [7:0] next_rampCount;
    logic rampGo;
    logic advance;
    logic isNormal;
    logic isPrbs;
    logic [127:0] fifoData;
    logic fifoValid;
    logic fifoPop;

    // Returns {state after eight bits, eight output bits, oldest first in msb}
    function automatic logic [38:0] prbsAdvance(input logic [30:0] s, input logic [3:0] mode);
        logic [30:0] st;
        logic [7:0] bits;
        logic nb;
        st = s;
        bits = '0;
        for (int i = 0; i < 8; i++) begin
            case (mode)
                stp_pkg::MODE_PRBS7: nb = st[stp_pkg::TAP7_A-1] ^ st[stp_pkg::TAP7_B-1];
                stp_pkg::MODE_PRBS9: nb = st[stp_pkg::TAP9_A-1] ^ st[stp_pkg::TAP9_B-1];
                stp_pkg::MODE_PRBS15: nb = st[stp_pkg::TAP15_A-1] ^ st[stp_pkg::TAP15_B-1];
                stp_pkg::MODE_PRBS23: nb = st[stp_pkg::TAP23_A-1] ^ st[stp_pkg::TAP23_B-1];
                default: nb = st[stp_pkg::TAP31_A-1] ^ st[stp_pkg::TAP31_B-1];
            endcase
            st = {st[29:0], nb};
            bits[7-i] = nb;
        end
        return {st, bits};
    endfunction

    // Nibble n of the N' 12, F 8 frame on lane k
    function automatic logic [3:0] nib12(input logic [2:0] k, input logic [3:0] n);
        logic [3:0] w;
        logic [3:0] p;
        w = n / 4'd3;
        p = n % 4'd3;
        if (n == stp_pkg::LAST_NIBBLE) begin
            nib12 = stp_pkg::TAIL_NIBBLE;
        end else if (p == 4'h0) begin
            nib12 = stp_pkg::NIB_TOP - {1'b0, k};
        end else if (p == 4'h1) begin
            nib12 = {1'b0, k};
        end else begin
            nib12 = w + 4'h1;
        end
    endfunction

    stp_fifo #(
        .WIDTH(stp_pkg::SAMPLE_W),
        .DEPTH(stp_pkg::FIFO_DEPTH)
    ) sampleBuf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inData(sampleData),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    // latch selection only when link is down
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeMode <= stp_pkg::MODE_NORMAL;
        end else if (!linkEnable) begin
            activeMode <= testPatternSelect;
        end
    end

    assign isNormal = (activeMode == stp_pkg::MODE_NORMAL);
    assign isPrbs = (activeMode >= stp_pkg::MODE_PRBS7) && (activeMode <= stp_pkg::MODE_PRBS31);
    assign advance = linkEnable && linkReady;
    // samples drain only in normal mode
    assign fifoPop = isNormal && advance;

    assign rampGo = fmt64b66b ? serdesInitDone : ilaDone;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rampState <= stp_pkg::RAMP_IDLE;
        end else begin
            case (rampState)
                stp_pkg::RAMP_IDLE: begin
                    if (linkEnable && activeMode == stp_pkg::MODE_RAMP) begin
                        rampState <= stp_pkg::RAMP_WAIT;
                    end
                end
                stp_pkg::RAMP_WAIT: begin
                    if (!linkEnable) begin
                        rampState <= stp_pkg::RAMP_IDLE;
                    end else if (rampGo) begin
                        rampState <= stp_pkg::RAMP_RUN;
                    end
                end
                stp_pkg::RAMP_RUN: begin
                    if (!linkEnable) begin
                        rampState <= stp_pkg::RAMP_IDLE;
                    end
                end
                default: rampState <= stp_pkg::RAMP_IDLE;
            endcase
        end
    end

    // count to K-1, else natural wrap at 0xff
    assign rampOctet = multiframeStart ? stp_pkg::RAMP_START : rampCount;
    always_comb begin
        if (fmtFramesPerMulti <= stp_pkg::RAMP_K_LIMIT
                && {2'b00, rampOctet} == fmtFramesPerMulti - 10'h001) begin
            next_rampCount = stp_pkg::RAMP_START;
        end else begin
            next_rampCount = rampOctet + 8'h01;
        end
    end

    // Frame position, clock phase and ramp counters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            octetIdx <= '0;
            frameOdd <= 1'b0;
            clkPhase <= 1'b0;
            rampCount <= stp_pkg::RAMP_START;
        end else if (!linkEnable) begin
            octetIdx <= '0;
            frameOdd <= 1'b0;
            clkPhase <= 1'b0;
            rampCount <= stp_pkg::RAMP_START;
        end else if (linkReady) begin
            clkPhase <= ~clkPhase;
            if (octetIdx >= fmtOctetsPerFrame - 5'h01) begin
                octetIdx <= '0;
                frameOdd <= ~frameOdd;
            end else begin
                octetIdx <= octetIdx + 5'h01;
            end
            // Ramp held at zero until its start condition is met
            if (rampState == stp_pkg::RAMP_RUN) begin
                rampCount <= next_rampCount;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < stp_pkg::LANES; g++) begin : laneGen
            localparam logic [2:0] K_IDX = 3'(g % stp_pkg::LANES_PER_LINK);
            localparam logic [30:0] SEED = stp_pkg::PRBS_SEED_BASE | 31'(g + 1);
            logic [30:0] prbsState;
            logic [38:0] prbsNext;
            logic [7:0] next_oct;
            logic enabled;
            logic [7:0] laneOct;

            assign prbsNext = prbsAdvance(prbsState, activeMode);
            assign enabled = {1'b0, K_IDX} < fmtLanesPerLink;

            always_comb begin
                next_oct = 8'h00;
                case (activeMode)
                    stp_pkg::MODE_NORMAL: next_oct = fifoData[g*8 +: 8];
                    stp_pkg::MODE_PRBS7, stp_pkg::MODE_PRBS9, stp_pkg::MODE_PRBS15,
                    stp_pkg::MODE_PRBS23, stp_pkg::MODE_PRBS31: next_oct = prbsNext[7:0];
                    stp_pkg::MODE_CLOCK: next_oct = clkPhase ? stp_pkg::CLK_ZEROS
                        : stp_pkg::CLK_ONES;
                    stp_pkg::MODE_RAMP: next_oct = (rampState == stp_pkg::RAMP_RUN)
                        ? rampOctet : 8'h00;
                    stp_pkg::MODE_SHORT_TP: begin
                        if (fmtNPrime12) begin
                            // nibble pairs of the word table
                            if (fmtOctetsPerFrame == 5'h08) begin
                                next_oct = {nib12(K_IDX, {octetIdx[2:0], 1'b0}),
                                    nib12(K_IDX, {octetIdx[2:0], 1'b1})};
                            end
                        end else begin
                            next_oct = frameOdd ? stp_pkg::OCTET_MAX - {5'h00, K_IDX}
                                : {5'h00, K_IDX};
                        end
                    end
                    default: next_oct = 8'h00;
                endcase
                if (!enabled) begin
                    next_oct = 8'h00;
                end
            end

            // raw bits, no scrambler in this path
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    prbsState <= SEED;
                end else if (!linkEnable) begin
                    prbsState <= SEED;
                end else if (linkReady && isPrbs) begin
                    prbsState <= prbsNext[38:8];
                end
            end

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    laneOct <= 8'h00;
                end else if (advance && (!isNormal || fifoValid)) begin
                    laneOct <= next_oct;
                end
            end

            assign laneData[g*8 +: 8] = laneOct;
            assign lanePowerEn[g] = enabled;
        end
    endgenerate

    // Valid marks a fresh octet on every lane
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            laneValid <= 1'b0;
        end else if (!linkEnable) begin
            laneValid <= 1'b0;
        end else if (linkReady) begin
            laneValid <= !isNormal || fifoValid;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rawSerial <= 1'b0;
            transportOff <= 1'b0;
        end else begin
            rawSerial <= isPrbs || activeMode == stp_pkg::MODE_CLOCK;
            transportOff <= isPrbs || activeMode == stp_pkg::MODE_CLOCK
                || activeMode == stp_pkg::MODE_RAMP;
        end
    end
endmodule

// [tb/stp_rx_model.sv]
// Purpose: Far-side receiver: ready, init, alignment, multiframe marks
// Assumes: Init and alignment end a fixed few cycles after enable
// Notes: Stall halves the accept rate, no worse
`timescale 1ns/1ps
module stp_rx_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link control
    input wire logic linkEnable,
    input wire logic stall,
    input wire logic [9:0] fmtFramesPerMulti,
    // Link status
    output logic linkReady,
    output logic ilaDone,
    output logic serdesInitDone,
    output logic multiframeStart
);
    logic [3:0] initCnt;
    logic [9:0] frameCnt;
    assign serdesInitDone = initCnt >= 4'h4;
    assign ilaDone = initCnt >= 4'h8;
    assign multiframeStart = ilaDone && linkReady && frameCnt == 10'h0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            initCnt <= 4'h0;
            frameCnt <= 10'h0;
            linkReady <= 1'b1;
        end else begin
            initCnt <= !linkEnable ? 4'h0 : initCnt + 4'(initCnt != 4'hf);
            linkReady <= !stall || !linkReady;
            if (!ilaDone) begin
                frameCnt <= 10'h0;
            end else if (linkReady) begin
                frameCnt <= (frameCnt == fmtFramesPerMulti - 10'h1) ? 10'h0
                    : frameCnt + 10'h1;
            end
        end
    end
endmodule

// [tb/stp_test_patterns_props.sv]
// Purpose: Port checks for the lane test pattern block
// Assumes: One clock; selection held while the link is up
// Notes: Lanes 0 and 15 stand in for the rest, to keep it cheap
`timescale 1ns/1ps
module stp_test_patterns_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control and format
    input wire logic [3:0] testPatternSelect,
    input wire logic linkEnable,
    input wire logic [3:0] fmtLanesPerLink,
    input wire logic fmtNPrime12,
    input wire logic [4:0] fmtOctetsPerFrame,
    input wire logic [9:0] fmtFramesPerMulti,
    input wire logic linkReady,
    // Lane side
    input wire logic [127:0] laneData,
    input wire logic laneValid,
    input wire logic rawSerial,
    input wire logic transportOff,
    input wire logic [15:0] lanePowerEn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic ramp;
    logic alt;
    assign ramp = transportOff && !rawSerial && laneValid;
    // Lane 0 flips each octet in clock and short N'8 F1
    assign alt = linkEnable && linkReady && laneValid && fmtLanesPerLink != 4'h0
        && (testPatternSelect == stp_pkg::MODE_CLOCK || (!fmtNPrime12
        && testPatternSelect == stp_pkg::MODE_SHORT_TP && fmtOctetsPerFrame == 5'h1));
    a_power_fmt: assert property (
        lanePowerEn == {2{8'((16'h1 << fmtLanesPerLink) - 16'h1)}})
        else $error("lane power differs from format");
    a_stall_hold: assert property (linkEnable && !linkReady
        |=> $stable(laneData) && $stable(laneValid))
        else $error("lane output moved while stalled");
    a_off_invalid: assert property (!linkEnable |=> !laneValid)
        else $error("lane valid while link down");
    a_raw_mode: assert property (linkEnable && $past(linkEnable)
        |-> rawSerial == (testPatternSelect inside {[4'h1:4'h6]}))
        else $error("raw flag wrong for mode");
    a_transport_off: assert property (linkEnable && $past(linkEnable)
        |-> transportOff == (testPatternSelect inside {[4'h1:4'h7]}))
        else $error("transport flag wrong for mode");
    a_lane_alt: assert property (alt |=> laneData[7:0] == ~$past(laneData[7:0]))
        else $error("lane 0 did not alternate");
    a_ramp_lanes: assert property (ramp && fmtLanesPerLink == 4'h8
        |-> laneData[7:0] == laneData[127:120])
        else $error("ramp lanes differ");
    a_ramp_bound: assert property (ramp && fmtFramesPerMulti <= 10'h100
        |-> {2'b00, laneData[7:0]} < fmtFramesPerMulti)
        else $error("ramp beyond K");
    c_alt: cover property (alt && rawSerial);
    c_ramp_top: cover property (ramp && laneData[7:0] == 8'h03);
    c_stall: cover property (linkEnable && laneValid && !linkReady);
endmodule

// [tb/stp_test_patterns_tb.sv]
// Purpose: Self-checking bench for the lane test pattern block
// Assumes: Format inputs set by hand, no format decoder
// Notes: Expected octets are built from the pattern rules here
`timescale 1ns/1ps
module stp_test_patterns_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] testPatternSelect = 4'h0;
    logic linkEnable = 1'b0;
    logic [3:0] fmtLanesPerLink = 4'h8;
    logic fmtNPrime12 = 1'b0;
    logic [4:0] fmtOctetsPerFrame = 5'h1;
    logic [9:0] fmtFramesPerMulti = 10'h4;
    logic fmt64b66b = 1'b0;
    logic [127:0] sampleData = '0;
    logic sampleValid = 1'b0;
    logic stall = 1'b0;
    logic ilaDone, serdesInitDone, multiframeStart, linkReady;
    logic sampleReady, laneValid, rawSerial, transportOff;
    logic [127:0] laneData;
    logic [15:0] lanePowerEn;
    int nErrors = 0;
    int checks = 0;
    always #25 sys_clk = ~sys_clk;
    stp_test_patterns u_dut (.sys_clk, .rst_n, .testPatternSelect, .linkEnable,
        .fmtLanesPerLink, .fmtNPrime12, .fmtOctetsPerFrame, .fmtFramesPerMulti, .fmt64b66b,
        .ilaDone, .serdesInitDone, .multiframeStart, .linkReady, .sampleData, .sampleValid,
        .sampleReady, .laneData, .laneValid, .rawSerial, .transportOff, .lanePowerEn);
    stp_rx_model u_rx (.sys_clk, .rst_n, .linkEnable, .stall, .fmtFramesPerMulti,
        .linkReady, .ilaDone, .serdesInitDone, .multiframeStart);
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            nErrors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic start(input logic [3:0] mode);
        linkEnable = 1'b0;
        testPatternSelect = mode;
        step(2);
        linkEnable = 1'b1;
    endtask
    task automatic conclude();
        if (nErrors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_clock();
        start(stp_pkg::MODE_CLOCK);
        for (int i = 0; i < 6; i++) begin
            step(1);
            chk(laneData === {16{i[0] ? 8'h00 : 8'hff}}, "clock octet");
            chk(rawSerial === 1'b1 && transportOff === 1'b1, "clock bypass");
        end
    endtask
    task automatic t_prbs(input logic [3:0] mode, input int a, input int b);
        logic [63:0] y0;
        logic [63:0] y1;
        logic ok;
        start(mode);
        for (int i = 0; i < 8; i++) begin
            step(1);
            for (int j = 0; j < 8; j++) begin
                y0[8 * i + j] = laneData[7 - j];
                y1[8 * i + j] = laneData[15 - j];
            end
        end
        ok = y0 !== 64'h0;
        for (int n = b; n < 64; n++) ok &= y0[n] === (y0[n - a] ^ y0[n - b]);
        chk(ok, "prbs sequence");
        chk(y0 !== y1 && rawSerial === 1'b1, "prbs phase");
    endtask
    task automatic t_ramp(input logic e64, input logic [9:0] k);
        logic [7:0] prev;
        logic [7:0] top;
        logic [7:0] want;
        prev = 8'h0;
        top = 8'h0;
        want = (k > 10'h100) ? stp_pkg::OCTET_MAX : 8'(k - 10'h1);
        fmt64b66b = e64;
        fmtFramesPerMulti = k;
        // Long multiframes run unstalled so the octet reaches its wrap in time
        stall = (k <= 10'h100);
        start(stp_pkg::MODE_RAMP);
        for (int i = 0; i < ((k > 10'h100) ? 300 : 60); i++) begin
            step(1);
            if ((e64 ? serdesInitDone : ilaDone) !== 1'b1)
                chk(laneData[7:0] === 8'h0, "ramp early");
            else if (laneData[7:0] !== prev)
                chk(laneData[7:0] === prev + 8'h1 || laneData[7:0] === 8'h0, "ramp step");
            if (laneData[7:0] > top) top = laneData[7:0];
            prev = laneData[7:0];
        end
        chk(top === want, "ramp top");
        chk(transportOff === 1'b1 && rawSerial === 1'b0, "ramp flags");
        stall = 1'b0;
    endtask
    task automatic t_short(input logic n12, input logic e64);
        logic [63:0] s;
        logic [3:0] k;
        fmtNPrime12 = n12;
        fmt64b66b = e64;
        fmtOctetsPerFrame = n12 ? 5'h8 : 5'h1;
        fmtLanesPerLink = n12 ? 4'h8 : 4'h4;
        start(stp_pkg::MODE_SHORT_TP);
        for (int o = 0; o < 8; o++) begin
            step(1);
            for (int l = 0; l < 16; l++) begin
                k = 4'(l % 8);
                s = {4'hf - k, k, 4'h1, 4'hf - k, k, 4'h2, 4'hf - k, k, 4'h3, 4'hf - k, k,
                    4'h4, 4'hf - k, k, 4'h5, stp_pkg::TAIL_NIBBLE};
                if (n12) chk(laneData[8 * l +: 8] === s[63 - 8 * o -: 8], "short n12");
                else chk(laneData[8 * l +: 8] === (k > 4'h3 ? 8'h0 : {4'h0, k} ^ {8{o[0]}}),
                    "short n8");
            end
        end
        chk(transportOff === 1'b0 && rawSerial === 1'b0, "short flags");
        chk(lanePowerEn === (n12 ? 16'hffff : 16'h0f0f), "short power");
    endtask
    task automatic t_reset();
        linkEnable = 1'b0;
        stall = 1'b0;
        rst_n = 1'b0;
        step(2);
        chk(laneData === '0 && laneValid === 1'b0 && rawSerial === 1'b0, "reset lanes");
        chk(transportOff === 1'b0 && sampleReady === 1'b1, "reset flags");
        rst_n = 1'b1;
        step(2);
    endtask
    task automatic t_other();
        start(4'h9);
        step(3);
        chk(laneData === '0 && laneValid === 1'b1, "unused code data");
        chk(rawSerial === 1'b0 && transportOff === 1'b0, "unused code flags");
    endtask
    task automatic t_fifo();
        int taken;
        int got;
        logic r;
        taken = 0;
        got = 0;
        linkEnable = 1'b0;
        stall = 1'b1;
        for (int i = 0; i < 40 && sampleReady === 1'b1; i++) begin
            sampleData = {16{8'(i)}};
            sampleValid = 1'b1;
            step(1);
            taken++;
        end
        sampleValid = 1'b0;
        chk(taken == stp_pkg::FIFO_DEPTH, "fifo depth");
        start(stp_pkg::MODE_NORMAL);
        for (int i = 0; i < 200 && got < 32; i++) begin
            r = linkReady;
            step(1);
            if (r === 1'b1 && laneValid === 1'b1) begin
                chk(laneData === {16{8'(got)}}, "fifo order");
                got++;
            end
        end
        chk(got == 32 && sampleReady === 1'b1, "fifo drained");
    endtask
    initial begin
        step(10);
        rst_n = 1'b1;
        step(1);
        t_clock();
        t_prbs(stp_pkg::MODE_PRBS7, stp_pkg::TAP7_A, stp_pkg::TAP7_B);
        t_prbs(stp_pkg::MODE_PRBS9, stp_pkg::TAP9_A, stp_pkg::TAP9_B);
        t_prbs(stp_pkg::MODE_PRBS15, stp_pkg::TAP15_A, stp_pkg::TAP15_B);
        t_prbs(stp_pkg::MODE_PRBS23, stp_pkg::TAP23_A, stp_pkg::TAP23_B);
        t_prbs(stp_pkg::MODE_PRBS31, stp_pkg::TAP31_A, stp_pkg::TAP31_B);
        t_ramp(1'b0, 10'h004);
        t_ramp(1'b1, 10'h004);
        t_ramp(1'b0, 10'h12c);
        t_short(1'b0, 1'b0);
        t_short(1'b0, 1'b1);
        t_short(1'b1, 1'b0);
        t_fifo();
        t_reset();
        t_other();
        conclude();
    end
    initial begin
        #500000;
        nErrors++;
        conclude();
    end
endmodule
bind stp_test_patterns stp_test_patterns_props u_props (.sys_clk, .rst_n, .testPatternSelect,
    .linkEnable, .fmtLanesPerLink, .fmtNPrime12, .fmtOctetsPerFrame, .fmtFramesPerMulti,
    .linkReady, .laneData, .laneValid, .rawSerial, .transportOff, .lanePowerEn);
